// ---- rtl/mem_addr_cfg.svh ----
/*
 * Constants for the CPU memory access and operand addressing unit:
 * address map boundaries, status byte fields and reset values.
 * Assumes it is included by bare name from the package and the modules.
 */
// Functional notes
// - low PC byte driven, then port floats
// - latch pulse while low address valid
// - high PC byte on high port during fetch
// - program strobe enables memory, byte sampled
// - program addresses always 16 bits wide
// - read/store strobes for external data
// - data address one or two bytes wide
// - above 7FH: direct special, indirect upper
// - lower 128 reachable direct and indirect
// - upper 128 reachable only indirectly
// - special registers reachable only directly
// - four banks of eight working registers
// - 3-bit opcode field picks working register
// - bit addresses 00H-7FH in byte area
// - bit addresses 80H-FFH in special space
// - status byte holds all listed flags
// - carry doubles as Boolean accumulator
// - parity makes accumulator ones even
// - two user flags simply store writes
// - direct address from 8-bit instruction field
// - indirect pointers R0/R1/SP or data pointer
// - indexed reads program memory, base plus acc
// - program strobe only on external fetches
// - strap low sends all fetches external
// - fetching starts at 0000H after reset
`ifndef MEM_ADDR_CFG_SVH
`define MEM_ADDR_CFG_SVH

`define PC_RESET_VAL      16'h0000
`define LOWER_TOP         8'h7F
`define BIT_AREA_BASE     8'h20
`define STATUS_SFR_ADDR   8'hD0
`define STATUS_RESET_VAL  8'h00
`define ONCHIP_ROM_BYTES  4096
`define ST_CARRY          7
`define ST_HALF_CARRY     6
`define ST_USER_HI        5
`define ST_BANK_HI        4
`define ST_BANK_LO        3
`define ST_SIGN_ERR       2
`define ST_USER_LO        1
`define ST_PARITY         0

`endif

// ---- rtl/mem_addr_pkg.sv ----
/*
 * Types and decode functions shared by the addressing unit and its
 * testbench. Assumes mem_addr_cfg.svh is on the include path.
 */
package mem_addr_pkg;
`include "mem_addr_cfg.svh"

	typedef enum logic [1:0] {SPACE_LOWER, SPACE_UPPER, SPACE_SPECIAL} space_t;
	typedef enum logic [2:0] {
		OP_DIRECT, OP_IND_REG, OP_IND_SP, OP_REGISTER, OP_IMMEDIATE
	} op_mode_t;
	typedef enum logic [1:0] {FETCH_PC, FETCH_IDX_DATA_POINTER_16, FETCH_IDX_PC} fetch_sel_t;
	typedef enum logic [2:0] {
		BUS_IDLE, BUS_ROM, BUS_ADDR, BUS_HOLD, BUS_STROBE
	} bus_state_t;
	typedef enum logic [1:0] {KIND_CODE, KIND_XRD, KIND_XWR} bus_kind_t;

	// one-byte internal address: same upper half means two places
	function automatic space_t space_of(input logic [7:0] addr,
		input logic indirect);
		if (addr <= `LOWER_TOP)
			return SPACE_LOWER;
		else if (indirect)
			return SPACE_UPPER;
		else
			return SPACE_SPECIAL;
	endfunction

	// byte that holds a given bit address
	function automatic logic [7:0] bit_byte_addr(input logic [7:0] baddr);
		if (baddr[7])
			return {baddr[7:3], 3'h0};
		else
			return `BIT_AREA_BASE + {4'h0, baddr[6:3]};
	endfunction
endpackage

// ---- rtl/int_data_ram.sv ----
/*
 * Internal data RAM: lower 128 and upper 128 bytes as separate arrays.
 * Assumes the caller decodes the space; reads are combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module int_data_ram #(
	parameter int HALF_BYTES = 128
) (
	input  wire logic       clock_in,
	input  wire logic       clk_en_in,
	input  wire logic [6:0] ptr_addr_in,
	output logic      [7:0] ptr_data_out,
	input  wire logic [7:0] rd_addr_in,
	input  wire logic       rd_upper_in,
	output logic      [7:0] rd_data_out,
	input  wire logic [7:0] wr_addr_in,
	input  wire logic       wr_upper_in,
	input  wire logic       wr_en_in,
	input  wire logic [7:0] wr_data_in
);
	logic [7:0] lower_mem [HALF_BYTES];
	logic [7:0] upper_mem [HALF_BYTES];

	if (HALF_BYTES != 128) begin : g_size_chk
		$error("int_data_ram: each half must be 128 bytes");
	end

	// pointer port only ever looks at the register banks
	assign ptr_data_out = lower_mem[ptr_addr_in];
	assign rd_data_out  = rd_upper_in ? upper_mem[rd_addr_in[6:0]]
		: lower_mem[rd_addr_in[6:0]];

	// physically separate halves share the low seven address bits
	always_ff @(posedge clock_in) begin
		if (clk_en_in && wr_en_in) begin
			if (wr_upper_in)
				upper_mem[wr_addr_in[6:0]] <= wr_data_in;
			else
				lower_mem[wr_addr_in[6:0]] <= wr_data_in;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/cpu_memory_addressing_unit.sv ----
/*
 * Memory access and operand addressing unit of an 8-bit CPU: external
 * bus sequencer, internal data space decode, register banks, status
 * byte and operand address forming. Assumes one clock, synchronous
 * requests from the execution unit, and pins resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mem_addr_cfg.svh"
module cpu_memory_addressing_unit
	import mem_addr_pkg::*;
#(
	parameter int ROM_BYTES = `ONCHIP_ROM_BYTES
) (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        clk_en_in,
	input  wire logic        ext_access_strap_n_in,
	// fetch and external data requests
	input  wire logic        fetch_req_in,
	input  wire fetch_sel_t  fetch_sel_in,
	input  wire logic        jump_load_in,
	input  wire logic        jump_idx_in,
	input  wire logic [15:0] jump_addr_in,
	input  wire logic        data_pointer_16_load_in,
	input  wire logic [15:0] data_pointer_16_data_in,
	input  wire logic        xdata_req_in,
	input  wire logic        xdata_we_in,
	input  wire logic        xdata_wide_in,
	input  wire logic        xdata_ptr_sel_in,
	input  wire logic  [7:0] xdata_wdata_in,
	input  wire logic  [7:0] acc_in,
	output logic             bus_busy_out,
	output logic             bus_done_out,
	output logic       [7:0] bus_rdata_out,
	output logic      [15:0] pc_out,
	output logic      [15:0] data_pointer_16_out,
	// on-chip program memory
	output logic      [15:0] rom_addr_out,
	input  wire logic  [7:0] rom_data_in,
	// external bus pins
	input  wire logic  [7:0] muxed_addr_data_port_in,
	output logic       [7:0] muxed_addr_data_port_out,
	output logic             muxed_addr_data_port_oe_out,
	output logic       [7:0] high_addr_port_out,
	output logic             high_addr_port_oe_out,
	output logic             addr_latch_out,
	output logic             program_store_strobe_n_out,
	output logic             read_strobe_n_out,
	output logic             write_strobe_n_out,
	// operand access
	input  wire logic        op_req_in,
	input  wire op_mode_t    op_mode_in,
	input  wire logic  [7:0] op_field_in,
	input  wire logic  [2:0] op_reg_in,
	input  wire logic        op_we_in,
	input  wire logic  [7:0] op_wdata_in,
	input  wire logic  [7:0] sp_in,
	input  wire logic        bit_req_in,
	input  wire logic        bit_store_in,
	input  wire logic  [7:0] bit_addr_in,
	output logic       [7:0] op_rdata_out,
	output logic             op_valid_out,
	// other special registers live outside
	output logic       [7:0] sfr_addr_out,
	output logic       [7:0] sfr_wdata_out,
	output logic             sfr_we_out,
	input  wire logic  [7:0] sfr_rdata_in,
	// arithmetic flag updates and status
	input  wire logic        alu_flags_we_in,
	input  wire logic        alu_carry_in,
	input  wire logic        alu_half_carry_in,
	input  wire logic        alu_sign_err_in,
	output logic       [7:0] cpu_status_byte_out
);
	if (ROM_BYTES < 0 || ROM_BYTES > 65536) begin : g_rom_chk
		$error("cpu_memory_addressing_unit: ROM_BYTES out of 16-bit space");
	end
	localparam logic [16:0] ROM_LIMIT = 17'(ROM_BYTES);

	bus_state_t  state_q, state_d;
	bus_kind_t   kind_q;
	logic [15:0] pc_q, data_pointer_16_q, bus_addr_q;
	logic [7:0]  wdata_q, rdata_q, op_rdata_q;
	logic        wide_q, done_q, op_valid_q;
	logic [7:1]  status_q;

	// program and indexed addresses, always 16 bits
	wire [15:0] idx_data_pointer_16_addr = data_pointer_16_q + {8'h00, acc_in};
	wire [15:0] idx_pc_addr   = pc_q + {8'h00, acc_in};
	wire [15:0] fetch_addr    = (fetch_sel_in == FETCH_IDX_DATA_POINTER_16) ? idx_data_pointer_16_addr
		: (fetch_sel_in == FETCH_IDX_PC) ? idx_pc_addr : pc_q;
	wire fetch_external = !ext_access_strap_n_in
		|| ({1'b0, fetch_addr} >= ROM_LIMIT);
	wire idle      = (state_q == BUS_IDLE);
	wire take_fetch = idle && fetch_req_in;
	wire take_xdata = idle && !fetch_req_in && xdata_req_in;

	// register banks: bank from status, reg from opcode field
	wire [1:0] bank = {status_q[`ST_BANK_HI], status_q[`ST_BANK_LO]};
	wire [2:0] ptr_reg = take_xdata ? {2'b00, xdata_ptr_sel_in}
		: {2'b00, op_field_in[0]};
	wire [7:0] ptr_val;
	wire [7:0] xdata_addr = ptr_val;

	// operand effective address per mode
	wire [7:0] reg_addr = {3'b000, bank, op_reg_in};
	wire       indirect = !bit_req_in
		&& (op_mode_in == OP_IND_REG || op_mode_in == OP_IND_SP);
	wire [7:0] eff_addr = bit_req_in ? bit_byte_addr(bit_addr_in)
		: (op_mode_in == OP_IND_REG) ? ptr_val
		: (op_mode_in == OP_IND_SP) ? sp_in
		: (op_mode_in == OP_REGISTER) ? reg_addr
		: op_field_in;
	wire space_t space = space_of(eff_addr, indirect);
	wire       is_status = (space == SPACE_SPECIAL)
		&& (eff_addr == `STATUS_SFR_ADDR);
	wire       parity = ^acc_in;
	wire [7:0] status_byte = {status_q, parity};
	wire [7:0] ram_rd;
	wire [7:0] space_rd = (space != SPACE_SPECIAL) ? ram_rd
		: is_status ? status_byte : sfr_rdata_in;
	wire       bit_val = space_rd[bit_addr_in[2:0]];
	wire [7:0] bit_mask = 8'h01 << bit_addr_in[2:0];
	wire [7:0] bit_merged = status_q[`ST_CARRY] ? (space_rd | bit_mask)
		: (space_rd & ~bit_mask);
	wire op_read  = op_req_in && !bit_req_in;
	wire op_write = op_read && op_we_in && (op_mode_in != OP_IMMEDIATE);
	wire bit_write = bit_req_in && bit_store_in;
	wire bit_load  = bit_req_in && !bit_store_in;
	wire wr_any   = op_write || bit_write;
	wire [7:0] wr_data = bit_req_in ? bit_merged : op_wdata_in;
	wire ram_we   = wr_any && (space != SPACE_SPECIAL);
	wire status_we = wr_any && is_status;

	int_data_ram u_ram (
		.clock_in    (clock_in),
		.clk_en_in   (clk_en_in),
		.ptr_addr_in ({2'b00, bank, ptr_reg}),
		.ptr_data_out(ptr_val),
		.rd_addr_in  (eff_addr),
		.rd_upper_in (space == SPACE_UPPER),
		.rd_data_out (ram_rd),
		.wr_addr_in  (eff_addr),
		.wr_upper_in (space == SPACE_UPPER),
		.wr_en_in    (ram_we),
		.wr_data_in  (wr_data)
	);

	// other special registers: write strobe, data goes straight out
	assign sfr_addr_out  = eff_addr;
	assign sfr_wdata_out = wr_data;
	assign sfr_we_out    = clk_en_in && wr_any
		&& (space == SPACE_SPECIAL) && !is_status;

	// bus sequencer next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			BUS_IDLE: begin
				if (take_fetch)
					state_d = fetch_external ? BUS_ADDR : BUS_ROM;
				else if (take_xdata)
					state_d = BUS_ADDR;
			end
			BUS_ROM:    state_d = BUS_IDLE;
			BUS_ADDR:   state_d = BUS_HOLD;
			BUS_HOLD:   state_d = BUS_STROBE;
			BUS_STROBE: state_d = BUS_IDLE;
		endcase
	end

	// pins: address phase then data phase on the shared port
	wire addr_phase = (state_q == BUS_ADDR) || (state_q == BUS_HOLD);
	wire strobe     = (state_q == BUS_STROBE);
	assign addr_latch_out = (state_q == BUS_ADDR);
	assign muxed_addr_data_port_out = addr_phase ? bus_addr_q[7:0] : wdata_q;
	assign muxed_addr_data_port_oe_out = addr_phase
		|| (strobe && kind_q == KIND_XWR);
	assign high_addr_port_out = bus_addr_q[15:8];
	assign high_addr_port_oe_out = (addr_phase || strobe)
		&& (kind_q == KIND_CODE || wide_q);
	assign program_store_strobe_n_out = !(strobe && kind_q == KIND_CODE);
	assign read_strobe_n_out  = !(strobe && kind_q == KIND_XRD);
	assign write_strobe_n_out = !(strobe && kind_q == KIND_XWR);
	assign rom_addr_out = bus_addr_q;
	assign bus_busy_out = !idle;
	assign bus_done_out = done_q;
	assign bus_rdata_out = rdata_q;
	assign pc_out = pc_q;
	assign data_pointer_16_out = data_pointer_16_q;
	assign op_rdata_out = op_rdata_q;
	assign op_valid_out = op_valid_q;
	assign cpu_status_byte_out = status_byte;

	// bus state and captured address; reset wins over the enable
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state_q    <= BUS_IDLE;
			kind_q     <= KIND_CODE;
			bus_addr_q <= `PC_RESET_VAL;
			wdata_q    <= 8'h00;
			wide_q     <= 1'b0;
		end else if (clk_en_in) begin
			state_q <= state_d;
			if (take_fetch) begin
				kind_q     <= KIND_CODE;
				bus_addr_q <= fetch_addr;
			end else if (take_xdata) begin
				kind_q     <= xdata_we_in ? KIND_XWR : KIND_XRD;
				bus_addr_q <= xdata_wide_in ? data_pointer_16_q : {8'h00, xdata_addr};
				wdata_q    <= xdata_wdata_in;
				wide_q     <= xdata_wide_in;
			end
		end
	end

	// code and data bytes sampled as the strobe or the on-chip ROM cycle ends
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rdata_q <= 8'h00;
			done_q  <= 1'b0;
		end else if (clk_en_in) begin
			done_q <= (state_q == BUS_ROM) || strobe;
			if (state_q == BUS_ROM)
				rdata_q <= rom_data_in;
			else if (strobe && kind_q != KIND_XWR)
				rdata_q <= muxed_addr_data_port_in;
		end
	end

	// program counter steps only on a plain fetch; jumps reload it
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pc_q   <= `PC_RESET_VAL;
			data_pointer_16_q <= 16'h0000;
		end else if (clk_en_in) begin
			if (jump_idx_in)
				pc_q <= idx_data_pointer_16_addr;
			else if (jump_load_in)
				pc_q <= jump_addr_in;
			else if (take_fetch && fetch_sel_in == FETCH_PC)
				pc_q <= pc_q + 16'h0001;
			if (data_pointer_16_load_in)
				data_pointer_16_q <= data_pointer_16_data_in;
		end
	end

	// operand read result registered for one cycle
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			op_rdata_q <= 8'h00;
			op_valid_q <= 1'b0;
		end else if (clk_en_in) begin
			op_valid_q <= op_read || bit_load;
			op_rdata_q <= (op_mode_in == OP_IMMEDIATE) ? op_field_in
				: bit_req_in ? {7'h00, bit_val} : space_rd;
		end
	end

	// status byte: hardware flag updates win over a software write
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			status_q <= 7'(`STATUS_RESET_VAL >> 1);
		end else if (clk_en_in) begin
			if (status_we)
				status_q <= wr_data[7:1];
			if (bit_load)
				status_q[`ST_CARRY] <= bit_val;
			if (alu_flags_we_in) begin
				status_q[`ST_CARRY]      <= alu_carry_in;
				status_q[`ST_HALF_CARRY] <= alu_half_carry_in;
				status_q[`ST_SIGN_ERR]   <= alu_sign_err_in;
			end
		end
	end

	// checks stand next to the logic they guard
	strobe_external_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		!program_store_strobe_n_out |-> kind_q == KIND_CODE
			&& $past(state_q) == BUS_HOLD && muxed_addr_data_port_oe_out == 1'b0)
		else $error("program strobe outside an external fetch");
	latch_addr_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		addr_latch_out && clk_en_in |=> !addr_latch_out
			&& muxed_addr_data_port_out == $past(bus_addr_q[7:0]))
		else $error("latch pulse not paired with valid low address");
	fetch_float_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(state_q == BUS_HOLD && kind_q != KIND_XWR && clk_en_in)
			|=> !muxed_addr_data_port_oe_out)
		else $error("port still driven while waiting for data");
	high_byte_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(!idle && kind_q == KIND_CODE && state_q != BUS_ROM)
			|-> high_addr_port_oe_out && high_addr_port_out == bus_addr_q[15:8])
		else $error("high address missing during fetch");
	strap_ext_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(take_fetch && clk_en_in && !ext_access_strap_n_in)
			|=> state_q == BUS_ADDR ##2 !program_store_strobe_n_out)
		else $error("fetch not sent external with strap low");
	narrow_free_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(take_xdata && clk_en_in && !xdata_wide_in)
			|=> !high_addr_port_oe_out [*3])
		else $error("high port driven on one-byte data access");
	parity_even_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		^{acc_in, cpu_status_byte_out[`ST_PARITY]} == 1'b0)
		else $error("parity bit does not make ones even");
	pc_reset_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		$past(!rst_n_in) |-> pc_q == `PC_RESET_VAL)
		else $error("fetch address not zero after reset");
	direct_special_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(op_req_in && !bit_req_in && op_mode_in == OP_DIRECT
			&& op_field_in[7]) |-> space == SPACE_SPECIAL && !ram_we)
		else $error("direct address reached upper RAM");
	bank_reg_a: assert property (@(posedge clock_in)
		disable iff (!rst_n_in)
		(op_req_in && !bit_req_in && op_mode_in == OP_REGISTER)
			|-> eff_addr == {3'b000, cpu_status_byte_out[4:3], op_reg_in})
		else $error("register operand outside the selected bank");
endmodule
`default_nettype wire

// ---- testbench/ext_memory_model.sv ----
/*
 * External program memory and external data RAM on the multiplexed bus,
 * with the address latch between them. Assumes the pin outputs of the
 * addressing unit and one clock; it returns the resolved bus level.
 */
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model (
	input  wire logic       clock_in,
	input  wire logic [7:0] drv_in,
	input  wire logic       drv_oe_in,
	input  wire logic [7:0] high_in,
	input  wire logic       high_oe_in,
	input  wire logic       latch_in,
	input  wire logic       prog_n_in,
	input  wire logic       rd_n_in,
	input  wire logic       wr_n_in,
	output logic      [7:0] wire_out
);
	logic [7:0]  low_q  = 8'h00;
	logic [7:0]  last_q = 8'h00;
	logic [7:0]  xram [0:65535];
	logic [15:0] addr;

	// a narrow access leaves the high port as plain i/o, read here as zero
	assign addr = {high_oe_in ? high_in : 8'h00, low_q};

	// memory drives only under its strobe; a floating bus shows the
	// inverse of its last level so a stale byte never passes as data
	always_comb begin
		if (drv_oe_in)
			wire_out = drv_in;
		else if (!prog_n_in)
			wire_out = addr[7:0] ^ addr[15:8] ^ 8'h5A;
		else if (!rd_n_in)
			wire_out = xram[addr];
		else
			wire_out = ~last_q;
	end

	// latch captures the low byte while the pulse is up
	always @(posedge clock_in) begin
		last_q <= wire_out;
		if (latch_in)
			low_q <= drv_in;
		if (!wr_n_in)
			xram[addr] <= drv_in;
	end
endmodule
`default_nettype wire

// ---- testbench/cpu_memory_addressing_unit_bench.sv ----
/*
 * Self-checking bench for the addressing unit: bus walks, spaces, banks,
 * bits and status. Assumes the external memory model on the bus pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mem_addr_cfg.svh"
module cpu_memory_addressing_unit_bench
	import mem_addr_pkg::*;
;
	localparam int ROM_SMALL = 256;
	localparam int LIMIT     = 3000;
	logic clock_in = 0, rst_n_in = 0, clk_en_in = 1, ext_access_strap_n_in = 0;
	logic fetch_req_in = 0, jump_load_in = 0, jump_idx_in = 0, data_pointer_16_load_in = 0;
	fetch_sel_t fetch_sel_in = FETCH_PC;
	op_mode_t op_mode_in = OP_DIRECT;
	logic [15:0] jump_addr_in = 16'h0000, data_pointer_16_data_in = 16'h0000;
	logic xdata_req_in = 0, xdata_we_in = 0, xdata_wide_in = 0;
	logic xdata_ptr_sel_in = 0, op_req_in = 0, op_we_in = 0, bit_req_in = 0;
	logic bit_store_in = 0, alu_flags_we_in = 0, alu_carry_in = 0;
	logic alu_half_carry_in = 0, alu_sign_err_in = 0;
	logic [7:0] xdata_wdata_in = 8'h00, acc_in = 8'h00, op_field_in = 8'h00;
	logic [7:0] op_wdata_in = 8'h00, sp_in = 8'h00, bit_addr_in = 8'h00;
	logic [7:0] sfr_rdata_in = 8'hC6;
	logic [2:0] op_reg_in = 3'h0;
	logic [7:0] rom_data_in, muxed_addr_data_port_in, bus_rdata_out;
	logic [7:0] muxed_addr_data_port_out, high_addr_port_out, op_rdata_out;
	logic [7:0] sfr_addr_out, sfr_wdata_out, cpu_status_byte_out;
	logic [15:0] pc_out, data_pointer_16_out, rom_addr_out;
	logic bus_busy_out, bus_done_out, muxed_addr_data_port_oe_out, sfr_we_out;
	logic high_addr_port_oe_out, addr_latch_out, program_store_strobe_n_out;
	logic read_strobe_n_out, write_strobe_n_out, op_valid_out;
	int fails = 0, comparisons = 0, cycles = 0;

	cpu_memory_addressing_unit #(.ROM_BYTES(ROM_SMALL)) i_dut (.*);
	ext_memory_model i_mem (.clock_in(clock_in),
		.drv_in(muxed_addr_data_port_out), .drv_oe_in(muxed_addr_data_port_oe_out),
		.high_in(high_addr_port_out), .high_oe_in(high_addr_port_oe_out),
		.latch_in(addr_latch_out), .prog_n_in(program_store_strobe_n_out),
		.rd_n_in(read_strobe_n_out), .wr_n_in(write_strobe_n_out),
		.wire_out(muxed_addr_data_port_in));

	// on-chip program bytes follow a simple pattern of their address
	assign rom_data_in = rom_addr_out[7:0] ^ 8'hC3;

	always #12.5 clock_in = ~clock_in;

	// a hang counts as a mismatch and ends the run
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check_word(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		check_word(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	function automatic logic [7:0] code_at(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction

	// one multiplexed bus transfer, walked from the cycle after its take
	task automatic bus_walk(input bus_kind_t k, input logic [15:0] a,
		input logic wide, input logic [7:0] wd, output logic [7:0] rd);
		@(negedge clock_in);
		fetch_req_in = 0;
		xdata_req_in = 0;
		check_bit("busy", 1, bus_busy_out);
		check_bit("latch", 1, addr_latch_out);
		check_bit("port_oe", 1, muxed_addr_data_port_oe_out);
		check_word("port_low", a[7:0], muxed_addr_data_port_out);
		check_bit("high_oe", wide, high_addr_port_oe_out);
		if (wide)
			check_word("high", a[15:8], high_addr_port_out);
		@(negedge clock_in);
		check_bit("latch_off", 0, addr_latch_out);
		@(negedge clock_in);
		check_bit("prog_strobe", k != KIND_CODE, program_store_strobe_n_out);
		check_bit("rd_strobe", k != KIND_XRD, read_strobe_n_out);
		check_bit("wr_strobe", k != KIND_XWR, write_strobe_n_out);
		check_bit("port_oe_data", k == KIND_XWR, muxed_addr_data_port_oe_out);
		check_bit("high_oe_held", wide, high_addr_port_oe_out);
		if (k == KIND_XWR)
			check_word("port_wdata", wd, muxed_addr_data_port_out);
		@(negedge clock_in);
		check_bit("done", 1, bus_done_out);
		rd = bus_rdata_out;
	endtask

	task automatic ext_fetch(input fetch_sel_t s, input logic [15:0] a);
		logic [7:0] rd;
		fetch_sel_in = s;
		fetch_req_in = 1;
		bus_walk(KIND_CODE, a, 1'b1, 8'h00, rd);
		check_word("code", code_at(a), rd);
	endtask

	task automatic xdata(input logic we, input logic wide, input logic ptr,
		input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rd);
		xdata_we_in = we;
		xdata_wide_in = wide;
		xdata_ptr_sel_in = ptr;
		xdata_wdata_in = wd;
		xdata_req_in = 1;
		bus_walk(we ? KIND_XWR : KIND_XRD, a, wide, wd, rd);
	endtask

	task automatic int_fetch(input logic [15:0] a);
		fetch_sel_in = FETCH_PC;
		fetch_req_in = 1;
		@(negedge clock_in);
		fetch_req_in = 0;
		check_word("rom_addr", a, rom_addr_out);
		check_bit("prog_idle", 1, program_store_strobe_n_out);
		@(negedge clock_in);
		check_bit("done_int", 1, bus_done_out);
		check_bit("prog_idle2", 1, program_store_strobe_n_out);
		check_word("rom_byte", a[7:0] ^ 8'hC3, bus_rdata_out);
	endtask

	task automatic pulse3(input logic j, input logic x, input logic d);
		jump_load_in = j;
		jump_idx_in = x;
		data_pointer_16_load_in = d;
		@(negedge clock_in);
		jump_load_in = 0;
		jump_idx_in = 0;
		data_pointer_16_load_in = 0;
	endtask

	// operand access; s says whether the outside special space is written
	task automatic op_acc(input op_mode_t m, input logic [7:0] f,
		input logic [2:0] r, input logic we, input logic [7:0] wd,
		input logic s, output logic [7:0] rd);
		op_mode_in = m;
		op_field_in = f;
		op_reg_in = r;
		op_we_in = we;
		op_wdata_in = wd;
		op_req_in = 1;
		#1;
		if (s !== 1'bx)
			check_bit("sfr_we", s, sfr_we_out);
		if (s === 1'b1)
			check_word("sfr_wr", {f, wd}, {sfr_addr_out, sfr_wdata_out});
		@(negedge clock_in);
		op_req_in = 0;
		if (!we)
			check_bit("op_valid", 1, op_valid_out);
		rd = op_rdata_out;
		@(negedge clock_in);
	endtask

	task automatic wr(input op_mode_t m, input logic [7:0] f, input logic [2:0] r,
		input logic [7:0] v, input logic s);
		logic [7:0] d;
		op_acc(m, f, r, 1'b1, v, s, d);
	endtask

	task automatic rd_op(input op_mode_t m, input logic [7:0] f, output logic [7:0] d);
		op_acc(m, f, 3'h0, 1'b0, 8'h00, 1'b0, d);
	endtask

	task automatic bit_op(input logic st, input logic [7:0] a);
		bit_store_in = st;
		bit_addr_in = a;
		bit_req_in = 1;
		#1;
		if (a[7])
			check_word("bit_sfr", {a[7:3], 3'h0}, sfr_addr_out);
		@(negedge clock_in);
		bit_req_in = 0;
		@(negedge clock_in);
	endtask

	task automatic set_flags(input logic c, input logic h, input logic s);
		alu_carry_in = c;
		alu_half_carry_in = h;
		alu_sign_err_in = s;
		alu_flags_we_in = 1;
		@(negedge clock_in);
		alu_flags_we_in = 0;
	endtask

	task automatic t_fetches();
		ext_fetch(FETCH_PC, 16'h0000);
		ext_fetch(FETCH_PC, 16'h0001);
		ext_access_strap_n_in = 1;
		int_fetch(16'h0002);
		jump_addr_in = 16'hA5C3;
		pulse3(1'b1, 1'b0, 1'b0);
		ext_fetch(FETCH_PC, 16'hA5C3);
		data_pointer_16_data_in = 16'h12F0;
		acc_in = 8'h25;
		pulse3(1'b0, 1'b0, 1'b1);
		check_word("data_pointer_16", 16'h12F0, data_pointer_16_out);
		ext_fetch(FETCH_IDX_DATA_POINTER_16, 16'h1315);
		ext_fetch(FETCH_IDX_PC, 16'hA5E9);
		pulse3(1'b0, 1'b1, 1'b0);
		check_word("pc_idx", 16'h1315, pc_out);
	endtask

	// a jump strobed while the enable is low must not move the counter
	task automatic t_freeze();
		clk_en_in = 0;
		pulse3(1'b1, 1'b0, 1'b0);
		check_word("pc_frozen", 16'h1315, pc_out);
		clk_en_in = 1;
	endtask

	task automatic t_xdata();
		logic [7:0] d;
		xdata(1'b1, 1'b1, 1'b0, 16'h12F0, 8'h6B, d);
		xdata(1'b0, 1'b1, 1'b0, 16'h12F0, 8'h00, d);
		check_word("xram_wide", 8'h6B, d);
		wr(OP_REGISTER, 8'h00, 3'h1, 8'h44, 1'b0);
		xdata(1'b1, 1'b0, 1'b1, 16'h0044, 8'h9E, d);
		xdata(1'b0, 1'b0, 1'b1, 16'h0044, 8'h00, d);
		check_word("xram_narrow", 8'h9E, d);
	endtask

	task automatic t_spaces();
		logic [7:0] d;
		for (int b = 0; b < 4; b++) begin
			wr(OP_DIRECT, `STATUS_SFR_ADDR, 3'h0, {3'h0, b[1:0], 3'h0}, 1'bx);
			check_word("bank", b[1:0], cpu_status_byte_out[4:3]);
			wr(OP_REGISTER, 8'h00, 3'(7 - b), 8'hA0 + 8'(b), 1'b0);
			rd_op(OP_DIRECT, 8'(7 * b + 7), d);
			check_word("bank_reg", 8'hA0 + 8'(b), d);
		end
		wr(OP_DIRECT, `STATUS_SFR_ADDR, 3'h0, 8'h00, 1'bx);
		wr(OP_DIRECT, 8'h45, 3'h0, 8'h71, 1'b0);
		wr(OP_REGISTER, 8'h00, 3'h0, 8'h45, 1'b0);
		rd_op(OP_IND_REG, 8'h00, d);
		check_word("lower_ind", 8'h71, d);
		wr(OP_DIRECT, 8'h90, 3'h0, 8'h33, 1'b1);
		wr(OP_REGISTER, 8'h00, 3'h0, 8'h90, 1'b0);
		wr(OP_IND_REG, 8'h00, 3'h0, 8'h5C, 1'b0);
		rd_op(OP_IND_REG, 8'h00, d);
		check_word("upper_ind", 8'h5C, d);
		sp_in = 8'h90;
		rd_op(OP_IND_SP, 8'h00, d);
		check_word("upper_sp", 8'h5C, d);
		rd_op(OP_DIRECT, 8'h90, d);
		check_word("special_dir", 8'hC6, d);
	endtask

	task automatic t_bits();
		logic [7:0] d;
		logic [7:0] vals [5] = '{8'h00, 8'h01, 8'h80, 8'hB5, 8'hFF};
		acc_in = 8'h00;
		wr(OP_DIRECT, 8'h21, 3'h0, 8'h00, 1'b0);
		set_flags(1'b1, 1'b1, 1'b1);
		check_word("flags", 8'hC4, cpu_status_byte_out);
		bit_op(1'b1, 8'h0B);
		rd_op(OP_DIRECT, 8'h21, d);
		check_word("bit_area", 8'h08, d);
		set_flags(1'b0, 1'b0, 1'b0);
		bit_op(1'b0, 8'h0B);
		check_bit("carry_bit", 1, cpu_status_byte_out[7]);
		bit_op(1'b0, 8'h83);
		check_bit("carry_sfr0", 0, cpu_status_byte_out[7]);
		bit_op(1'b0, 8'h82);
		check_bit("carry_sfr1", 1, cpu_status_byte_out[7]);
		set_flags(1'b0, 1'b0, 1'b0);
		// the parity bit is written as one here but must not take it
		wr(OP_DIRECT, `STATUS_SFR_ADDR, 3'h0, 8'h23, 1'bx);
		foreach (vals[i]) begin
			acc_in = vals[i];
			#1;
			check_word("status", 8'h22 | 8'($countones(vals[i]) % 2), cpu_status_byte_out);
		end
	endtask

	initial begin
		repeat (12) @(negedge clock_in);
		check_word("pc_rst", 16'h0000, pc_out);
		check_word("data_pointer_16_rst", 16'h0000, data_pointer_16_out);
		check_word("status_rst", 8'h00, cpu_status_byte_out);
		check_word("pins_rst", 6'h07, {muxed_addr_data_port_oe_out,
			high_addr_port_oe_out, addr_latch_out, program_store_strobe_n_out,
			read_strobe_n_out, write_strobe_n_out});
		rst_n_in = 1;
		@(negedge clock_in);
		t_fetches();
		t_freeze();
		t_xdata();
		t_spaces();
		t_bits();
		report_and_stop();
	end
endmodule
`default_nettype wire
